// *** verilog/dtu_defs.svh ***
// Constants of the dead-time unit: offsets, fields, reset values, keys.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef DTU_DEFS_SVH
`define DTU_DEFS_SVH

// Register byte offsets
`define DTU_OFS_ROUTE 8'h28
`define DTU_OFS_CTRL 8'h70
`define DTU_OFS_TIME 8'h74
`define DTU_OFS_FC 8'h78
`define DTU_OFS_OGEN 8'h7C
`define DTU_OFS_FSTAT 8'h80
`define DTU_OFS_FCLR 8'h84
`define DTU_OFS_LOCK 8'h88

// Control register fields
`define DTU_CTRL_EN 0
`define DTU_CTRL_POL 1
`define DTU_CTRL_CINV 2
`define DTU_CTRL_EVEN 3
`define DTU_CTRL_EVSEL 7:4
`define DTU_CTRL_DAS 8

// Timing register fields
`define DTU_TIME_PRESC 3:0
`define DTU_TIME_RISE 13:8
`define DTU_TIME_FALL 21:16

// Fault configuration fields
`define DTU_FC_EV0SEL 3:0
`define DTU_FC_EV1SEL 11:8
`define DTU_FC_FACT 17:16
`define DTU_FC_FSEN 27:24

// Other fields and widths
`define DTU_OGEN_F 5:0
`define DTU_ROUTE_F 5:0
`define DTU_FAULT_F 3:0
`define DTU_LOCK_KEY 15:0
`define DTU_UNLOCK_KEY 16'hCE80
`define DTU_NCH 3
`define DTU_NEV 16
`define DTU_PRESC_MAX 4'hA
`define DTU_PCNT_ONES 10'h3FF

// Fault source bit positions
`define DTU_FS_EV0 0
`define DTU_FS_EV1 1
`define DTU_FS_DBG 2
`define DTU_FS_LOCKUP 3

// Reset values
`define DTU_RST_6 6'h00
`define DTU_RST_4 4'h0
`define DTU_RST_3 3'h0
`define DTU_RST_32 32'h00000000

`endif

// *** verilog/dtu_pkg.sv ***
// Types of the dead-time unit: fault actions and module state records.
// Assumes dtu_defs.svh is on the include path.
`include "dtu_defs.svh"

package dtu_pkg;

	typedef enum logic [1:0] {
		DTU_FACT_INACTIVE = 2'b00,
		DTU_FACT_LOW = 2'b01,
		DTU_FACT_TRI = 2'b10
	} dtu_fact_e;

	typedef struct packed {
		logic [2:0] src_q;
		logic [2:0] busy;
		logic [2:0][5:0] cnt;
		logic [2:0] pri_act;
		logic [2:0] cmp_act;
	} dtu_chan_s;

	typedef struct packed {
		logic en;
		logic pol;
		logic cinv;
		logic ev_en;
		logic [3:0] ev_sel;
		logic das;
		logic [3:0] presc;
		logic [5:0] rise;
		logic [5:0] fall;
		logic [3:0] ev0_sel;
		logic [3:0] ev1_sel;
		logic [1:0] fact;
		logic [3:0] fsen;
		logic [5:0] ogen;
		logic [5:0] route;
		logic [3:0] fstat;
		logic locked;
		logic [9:0] pcnt;
		logic [31:0] rdata;
		logic [2:0] pri;
		logic [2:0] cmp;
		logic [2:0] pri_oe;
		logic [2:0] cmp_oe;
	} dtu_state_s;

endpackage : dtu_pkg

// *** verilog/dtu_chan_if.sv ***
// Link between the register side and the per-channel dead-time core.
// Assumes both ends share mclk.
interface dtu_chan_if;
	logic [2:0] src;
	logic [5:0] rise_len;
	logic [5:0] fall_len;
	logic tick;
	logic [2:0] pri_act;
	logic [2:0] cmp_act;

	modport ctl (output src, output rise_len, output fall_len,
		output tick, input pri_act, input cmp_act);
	modport core (input src, input rise_len, input fall_len,
		input tick, output pri_act, output cmp_act);
endinterface : dtu_chan_if

// *** verilog/dtu_chan.sv ***
// Dead-time core for the three channels: delays each activating edge.
// Assumes a prescaled tick one cycle wide and lengths held stable by software.
`include "dtu_defs.svh"

module dtu_chan
	import dtu_pkg::*;
(
	input wire logic mclk, // Peripheral clock
	input wire logic arst_n, // Asynchronous reset, active low
	dtu_chan_if.core link // Sources, timing and active flags
);

	dtu_chan_s s_r;
	dtu_chan_s s_nxt;

	// ****************************************
	// Edge detection and delay counting
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		for (int i = 0; i < `DTU_NCH; i++) begin
			s_nxt.src_q[i] = link.src[i];
			if (link.src[i] != s_r.src_q[i]) begin
				// Both sides inactive while the delay runs
				s_nxt.busy[i] = 1'b1;
				s_nxt.pri_act[i] = 1'b0;
				s_nxt.cmp_act[i] = 1'b0;
				s_nxt.cnt[i] = link.src[i] ? link.rise_len
					: link.fall_len;
			end else if (s_r.busy[i]) begin
				if (link.tick) begin
					if (s_r.cnt[i] == `DTU_RST_6) begin
						// Field value n gives n+1 ticks
						s_nxt.busy[i] = 1'b0;
						s_nxt.pri_act[i] = s_r.src_q[i];
						s_nxt.cmp_act[i] = ~s_r.src_q[i];
					end else begin
						s_nxt.cnt[i] = s_r.cnt[i] - 6'h01;
					end
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.pri_act = s_r.pri_act;
	assign link.cmp_act = s_r.cmp_act;

endmodule // dtu_chan

// *** verilog/dtu_top.sv ***
// Dead-time insertion unit: registers, source select, polarity, faults.
// Assumes synchronous inputs on mclk and a single-cycle strobe master.
`include "dtu_defs.svh"

// How it works
// - Enable replaces timer outputs, adds complements
// - Three primary and complementary output pairs
// - Every activating edge delayed, pair inactive
// - Rise and fall delays shared by channels
// - One prescaler, divide 1 to 1024
// - Delay lengths 1 to 64 ticks
// - Pair never active at same time, except low fault action with base polarity inverted and complement not inverted
// - Base polarity inverts whole pair
// - Complement invert flips complementary polarity
// - Per-output enable, disabled holds inactive
// - Event channel may feed first pair
// - Event source delay error from prescaler
// - Four fault sources individually enabled
// - Two selects pick fault event channels
// - Fault sets status bit, forces safe
// - Fault action: inactive, low, tristate
// - Inactive action drives opposite of active
// - Auto restart clears lone debugger fault
// - Fault state held while any bit set
// - Key unlocks route, control, timing and fault config (output enables never locked), other lock values lock it; reads lock state
module dtu_top
	import dtu_pkg::*;
(
	input wire logic mclk, // Peripheral clock, 100 MHz
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic [7:0] addr, // Register byte address
	input wire logic [31:0] wdata, // Write data
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	output logic [31:0] rdata, // Read data, cycle after strobe
	input wire logic [2:0] pwm_in, // Timer compare/PWM outputs
	input wire logic [15:0] event_channel, // Event channel levels
	input wire logic dbg_halt, // Processor halted by debugger
	input wire logic core_lockup, // Processor core lockup
	output logic [2:0] primary_out, // Primary gate drives
	output logic [2:0] primary_oe, // Primary output enables
	output logic [2:0] compl_out, // Complementary gate drives
	output logic [2:0] compl_oe // Complementary output enables
);

	dtu_state_s s_r;
	dtu_state_s s_nxt;
	dtu_chan_if link ();

	logic wr_route;
	logic wr_ctrl;
	logic wr_time;
	logic wr_fc;
	logic [9:0] pmask;
	logic [3:0] presc_eff;
	logic [3:0] fault_src;
	logic [3:0] fstat_set;
	logic [3:0] fstat_clr;
	logic [3:0] fstat_new;
	logic fault_on;
	logic [2:0] pri_lvl;
	logic [2:0] cmp_lvl;
	logic [2:0] pri_inact;
	logic [2:0] cmp_inact;

	// ****************************************
	// Dead-time core
	// ****************************************
	dtu_chan u_chan (
		.mclk(mclk),
		.arst_n(arst_n),
		.link(link)
	);

	// ****************************************
	// Source select and prescaled tick
	// ****************************************
	always_comb begin
		link.src = pwm_in;
		if (s_r.ev_en) begin
			link.src[0] = event_channel[s_r.ev_sel];
		end
	end

	assign link.rise_len = s_r.rise;
	assign link.fall_len = s_r.fall;

	// Settings above the largest divider act as divide by 1024
	assign presc_eff = (s_r.presc > `DTU_PRESC_MAX) ? `DTU_PRESC_MAX
		: s_r.presc;
	assign pmask = ~(`DTU_PCNT_ONES << presc_eff);
	// Free-running divider: an event edge lands anywhere in a tick
	assign link.tick = ((s_r.pcnt & pmask) == pmask);

	// ****************************************
	// Write decode with configuration lock
	// ****************************************
	assign wr_route = wr_en && (addr == `DTU_OFS_ROUTE) && !s_r.locked;
	assign wr_ctrl = wr_en && (addr == `DTU_OFS_CTRL) && !s_r.locked;
	assign wr_time = wr_en && (addr == `DTU_OFS_TIME) && !s_r.locked;
	assign wr_fc = wr_en && (addr == `DTU_OFS_FC) && !s_r.locked;

	// ****************************************
	// Fault detection
	// ****************************************
	always_comb begin
		fault_src = `DTU_RST_4;
		fault_src[`DTU_FS_EV0] = event_channel[s_r.ev0_sel];
		fault_src[`DTU_FS_EV1] = event_channel[s_r.ev1_sel];
		fault_src[`DTU_FS_DBG] = dbg_halt;
		fault_src[`DTU_FS_LOCKUP] = core_lockup;
	end

	assign fstat_set = fault_src & s_r.fsen;

	always_comb begin
		fstat_clr = `DTU_RST_4;
		if (wr_en && (addr == `DTU_OFS_FCLR)) begin
			fstat_clr = wdata[`DTU_FAULT_F];
		end
		// Debugger alone as cause, processor running again
		if (s_r.das && !dbg_halt
			&& (s_r.fstat == (4'h1 << `DTU_FS_DBG))) begin
			fstat_clr[`DTU_FS_DBG] = 1'b1;
		end
	end

	// A new fault wins over a clear in the same cycle
	assign fstat_new = (s_r.fstat & ~fstat_clr) | fstat_set;
	assign fault_on = |s_r.fstat;

	// ****************************************
	// Output polarity
	// ****************************************
	always_comb begin
		for (int i = 0; i < `DTU_NCH; i++) begin
			pri_inact[i] = s_r.pol;
			cmp_inact[i] = s_r.pol ^ s_r.cinv;
			pri_lvl[i] = link.pri_act[i] ^ pri_inact[i];
			cmp_lvl[i] = link.cmp_act[i] ^ cmp_inact[i];
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.pcnt = s_r.pcnt + 10'h001;

		if (wr_ctrl) begin
			s_nxt.en = wdata[`DTU_CTRL_EN];
			s_nxt.pol = wdata[`DTU_CTRL_POL];
			s_nxt.cinv = wdata[`DTU_CTRL_CINV];
			s_nxt.ev_en = wdata[`DTU_CTRL_EVEN];
			s_nxt.ev_sel = wdata[`DTU_CTRL_EVSEL];
			s_nxt.das = wdata[`DTU_CTRL_DAS];
		end
		if (wr_time) begin
			s_nxt.presc = wdata[`DTU_TIME_PRESC];
			s_nxt.rise = wdata[`DTU_TIME_RISE];
			s_nxt.fall = wdata[`DTU_TIME_FALL];
		end
		if (wr_fc) begin
			s_nxt.ev0_sel = wdata[`DTU_FC_EV0SEL];
			s_nxt.ev1_sel = wdata[`DTU_FC_EV1SEL];
			s_nxt.fact = wdata[`DTU_FC_FACT];
			s_nxt.fsen = wdata[`DTU_FC_FSEN];
		end
		if (wr_route) begin
			s_nxt.route = wdata[`DTU_ROUTE_F];
		end
		if (wr_en && (addr == `DTU_OFS_OGEN)) begin
			s_nxt.ogen = wdata[`DTU_OGEN_F];
		end
		if (wr_en && (addr == `DTU_OFS_LOCK)) begin
			s_nxt.locked = (wdata[`DTU_LOCK_KEY] != `DTU_UNLOCK_KEY);
		end

		s_nxt.fstat = fstat_new;

		// Read data stand only in the cycle after the strobe
		s_nxt.rdata = `DTU_RST_32;
		if (rd_en) begin
			unique case (addr)
				`DTU_OFS_ROUTE: begin
					s_nxt.rdata[`DTU_ROUTE_F] = s_r.route;
				end
				`DTU_OFS_CTRL: begin
					s_nxt.rdata[`DTU_CTRL_EN] = s_r.en;
					s_nxt.rdata[`DTU_CTRL_POL] = s_r.pol;
					s_nxt.rdata[`DTU_CTRL_CINV] = s_r.cinv;
					s_nxt.rdata[`DTU_CTRL_EVEN] = s_r.ev_en;
					s_nxt.rdata[`DTU_CTRL_EVSEL] = s_r.ev_sel;
					s_nxt.rdata[`DTU_CTRL_DAS] = s_r.das;
				end
				`DTU_OFS_TIME: begin
					s_nxt.rdata[`DTU_TIME_PRESC] = s_r.presc;
					s_nxt.rdata[`DTU_TIME_RISE] = s_r.rise;
					s_nxt.rdata[`DTU_TIME_FALL] = s_r.fall;
				end
				`DTU_OFS_FC: begin
					s_nxt.rdata[`DTU_FC_EV0SEL] = s_r.ev0_sel;
					s_nxt.rdata[`DTU_FC_EV1SEL] = s_r.ev1_sel;
					s_nxt.rdata[`DTU_FC_FACT] = s_r.fact;
					s_nxt.rdata[`DTU_FC_FSEN] = s_r.fsen;
				end
				`DTU_OFS_OGEN: begin
					s_nxt.rdata[`DTU_OGEN_F] = s_r.ogen;
				end
				`DTU_OFS_FSTAT: begin
					s_nxt.rdata[`DTU_FAULT_F] = s_r.fstat;
				end
				`DTU_OFS_LOCK: begin
					s_nxt.rdata[0] = s_r.locked;
				end
				default: begin
					s_nxt.rdata = `DTU_RST_32;
				end
			endcase
		end

		// Output stage
		for (int i = 0; i < `DTU_NCH; i++) begin
			if (!s_r.en) begin
				// Timer drives the primary pins directly
				s_nxt.pri[i] = pwm_in[i];
				s_nxt.pri_oe[i] = s_r.route[i];
				s_nxt.cmp[i] = 1'b0;
				s_nxt.cmp_oe[i] = 1'b0;
			end else begin
				s_nxt.pri[i] = s_r.ogen[i] ? pri_lvl[i]
					: pri_inact[i];
				s_nxt.cmp[i] = s_r.ogen[`DTU_NCH + i] ? cmp_lvl[i]
					: cmp_inact[i];
				s_nxt.pri_oe[i] = s_r.route[i];
				s_nxt.cmp_oe[i] = s_r.route[`DTU_NCH + i];
				if (fault_on) begin
					unique case (s_r.fact)
						DTU_FACT_LOW: begin
							s_nxt.pri[i] = 1'b0;
							s_nxt.cmp[i] = 1'b0;
						end
						DTU_FACT_TRI: begin
							s_nxt.pri_oe[i] = 1'b0;
							s_nxt.cmp_oe[i] = 1'b0;
						end
						default: begin
							s_nxt.pri[i] = pri_inact[i];
							s_nxt.cmp[i] = cmp_inact[i];
						end
					endcase
				end
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rdata = s_r.rdata;
	assign primary_out = s_r.pri;
	assign primary_oe = s_r.pri_oe;
	assign compl_out = s_r.cmp;
	assign compl_oe = s_r.cmp_oe;

endmodule // dtu_top

// *** dv/dtu_top_asserts.sv ***
// Port checker of the dead-time unit.
// Assumes bind onto dtu_top; shadows lock, control and fault config.
`include "dtu_defs.svh"
module dtu_top_asserts
	import dtu_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic arst_n, // Reset
	input wire logic [7:0] addr, // Address
	input wire logic [31:0] wdata, // Wdata
	input wire logic wr_en, // Write
	input wire logic rd_en, // Read
	input wire logic [31:0] rdata, // Rdata
	input wire logic [2:0] pwm_in, // Pwm
	input wire logic [15:0] event_channel, // Events
	input wire logic dbg_halt, // Halt
	input wire logic core_lockup, // Lockup
	input wire logic [2:0] primary_out, // Pri
	input wire logic [2:0] primary_oe, // Pri oe
	input wire logic [2:0] compl_out, // Cmp
	input wire logic [2:0] compl_oe // Cmp oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic lock_r;
	logic [8:0] ctrl_r;
	logic [31:0] fc_r;
	logic plain;
	// ****
	// Shadow registers
	// ****
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lock_r <= 1'b0;
			ctrl_r <= 9'h000;
			fc_r <= 32'h0;
		end else if (wr_en) begin
			if (addr == `DTU_OFS_LOCK)
				lock_r <= wdata[15:0] != `DTU_UNLOCK_KEY;
			if (addr == `DTU_OFS_CTRL && !lock_r)
				ctrl_r <= wdata[8:0];
			if (addr == `DTU_OFS_FC && !lock_r)
				fc_r <= wdata;
		end
	end
	assign plain = ctrl_r[2:0] == 3'h1;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// Timer source only: an event source ignores pwm_in[0]
	sequence s_rise;
		$rose(pwm_in[0]) && plain && !ctrl_r[3] && $stable(ctrl_r);
	endsequence
	sequence s_fall;
		$fell(pwm_in[0]) && plain && !ctrl_r[3] && $stable(ctrl_r);
	endsequence
	sequence s_gap;
		primary_out[0] == 1'b0 && compl_out[0] == 1'b0;
	endsequence
	AST_RISE_GAP: assert property (s_rise |-> ##2 s_gap)
		else $error("pair active after rise");
	AST_FALL_GAP: assert property (s_fall |-> ##2 s_gap)
		else $error("pair active after fall");
	AST_NO_SHOOT: assert property (plain && $stable(ctrl_r) |->
		(primary_out & compl_out & primary_oe & compl_oe) == 3'h0)
		else $error("pair both active");
	AST_DISABLED: assert property (!ctrl_r[0] && $past(!ctrl_r[0]) |->
		compl_oe == 3'h0 && primary_out == $past(pwm_in))
		else $error("disabled unit drives");
	AST_LOCK_RD: assert property (rd_en && addr == `DTU_OFS_LOCK
		|=> rdata == {31'h0, lock_r}) else $error("lock read");
	AST_CTRL_RD: assert property (rd_en && addr == `DTU_OFS_CTRL
		|=> rdata == {23'h0, ctrl_r}) else $error("control read");
	AST_FLT_LOW: assert property (core_lockup && fc_r[27] && ctrl_r[0]
		&& fc_r[17:16] == DTU_FACT_LOW |-> ##[2:3]
		(primary_out | compl_out) == 3'h0) else $error("fault not low");
	AST_FLT_TRI: assert property (core_lockup && fc_r[27] && ctrl_r[0]
		&& fc_r[17:16] == DTU_FACT_TRI |-> ##[2:3]
		(primary_oe | compl_oe) == 3'h0) else $error("fault not off");
endmodule // dtu_top_asserts

bind dtu_top dtu_top_asserts i_asserts (.mclk(mclk), .arst_n(arst_n),
	.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
	.rdata(rdata), .pwm_in(pwm_in), .event_channel(event_channel),
	.dbg_halt(dbg_halt), .core_lockup(core_lockup),
	.primary_out(primary_out), .primary_oe(primary_oe),
	.compl_out(compl_out), .compl_oe(compl_oe));

// *** dv/dtu_bridge.sv ***
// Triple half-bridge: conduction of each transistor.
// Assumes an undriven gate stays off.
module dtu_bridge (
	input wire logic [2:0] hs_gate, // High gates
	input wire logic [2:0] hs_en, // High enables
	input wire logic [2:0] ls_gate, // Low gates
	input wire logic [2:0] ls_en, // Low enables
	input wire logic hs_act, // High active level
	input wire logic ls_act, // Low active level
	output logic [2:0] hs_on, // High conducting
	output logic [2:0] ls_on // Low conducting
);
	timeunit 1ns;
	timeprecision 100ps;
	assign hs_on = hs_en & ~(hs_gate ^ {3{hs_act}});
	assign ls_on = ls_en & ~(ls_gate ^ {3{ls_act}});
endmodule // dtu_bridge

// *** dv/tb.sv ***
// Self-checking bench of the dead-time unit.
// Assumes dtu_top, its checker and the bridge model are compiled.
`include "dtu_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 0, arst_n = 0, wr_en = 0, rd_en = 0;
	logic dbg_halt = 0, core_lockup = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [2:0] pwm_in = 3'h0, src, hs_on, ls_on;
	logic [2:0] primary_out, primary_oe, compl_out, compl_oe;
	logic [15:0] event_channel = 16'h0, ev;
	logic [7:0] ofs[$] = '{8'h28, 8'h70, 8'h74, 8'h78, 8'h7C, 8'h80, 8'h88,
		8'h00};
	int fails = 0, num_checks = 0, seed = 32'h572bd4a1;
	int pol = 0, cinv = 0, ogen = 63, fact = 0, flt = 0, i, j, n, e0, p;
	always #5 mclk = ~mclk;
	dtu_top i_dut (.mclk(mclk), .arst_n(arst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.pwm_in(pwm_in), .event_channel(event_channel),
		.dbg_halt(dbg_halt), .core_lockup(core_lockup),
		.primary_out(primary_out), .primary_oe(primary_oe),
		.compl_out(compl_out), .compl_oe(compl_oe));
	dtu_bridge i_bridge (.hs_gate(primary_out), .hs_en(primary_oe),
		.ls_gate(compl_out), .ls_en(compl_oe), .hs_act(pol == 0),
		.ls_act((pol ^ cinv) == 0), .hs_on(hs_on), .ls_on(ls_on));
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic meas(input int ch, input logic lvl, input int d,
		input int p);
		@(posedge mclk);
		pwm_in[ch] <= lvl;
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while ((lvl ? primary_out[ch] : compl_out[ch]) !== 1'b1
			&& n < 200);
		// Two register stages, then d+1 ticks of 2^p cycles each
		chk((n - (d << p) - 3) >> p, 0);
		chk(lvl ? compl_out[ch] : primary_out[ch], 1'b0);
	endtask
	task automatic outs();
		logic [2:0] pa, ca, lp, lc, oe;
		#1;
		pa = src & ogen[2:0] & {3{flt == 0}};
		ca = ~src & ogen[5:3] & {3{flt == 0}};
		lp = (flt && fact == 1) ? 3'h0 : pa ^ {3{pol[0]}};
		lc = (flt && fact == 1) ? 3'h0 : ca ^ {3{pol[0] ^ cinv[0]}};
		oe = (flt && fact == 2) ? 3'h0 : 3'h7;
		chk({primary_out & oe, compl_out & oe, primary_oe, compl_oe},
			{lp & oe, lc & oe, oe, oe});
		chk(hs_on & ls_on, 3'h0);
		@(posedge mclk);
	endtask
	task automatic fsrc(input int s, input logic v);
		case (s)
			0: event_channel[e0] <= v;
			1: event_channel[e0 + 1] <= v;
			2: dbg_halt <= v;
			default: core_lockup <= v;
		endcase
	endtask
	task automatic results();
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		results;
	end
	// ****
	// Scenarios
	// ****
	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		foreach (ofs[k]) rd(ofs[k], 32'h0);
		wr(`DTU_OFS_ROUTE, 32'h3F);
		wr(`DTU_OFS_OGEN, 32'h3F);
		wr(`DTU_OFS_CTRL, 32'h1);
		for (i = 0; i < 4; i++) begin
			j = i == 0 ? 0 : i == 1 ? 63 : $random(seed) & 15;
			p = i == 2;
			wr(`DTU_OFS_TIME, ((63 - j) << 16) | (j << 8) | p);
			for (e0 = 0; e0 < 3; e0++) begin
				meas(e0, 1'b1, j, p);
				meas(e0, 1'b0, 63 - j, p);
			end
		end
		for (i = 0; i < 8; i++) begin
			pol = i & 1;
			cinv = (i >> 1) & 1;
			ogen = i < 4 ? 63 : $random(seed) & 63;
			src = 3'($random(seed));
			wr(`DTU_OFS_CTRL, 1 | (pol << 1) | (cinv << 2));
			wr(`DTU_OFS_OGEN, ogen);
			pwm_in <= src;
			repeat (80) @(posedge mclk);
			outs;
		end
		pol = 0;
		cinv = 0;
		ogen = 63;
		wr(`DTU_OFS_OGEN, 32'h3F);
		j = $random(seed) & 15;
		for (i = 0; i < 2; i++) begin
			wr(`DTU_OFS_CTRL, 9 | (j << 4));
			ev = 16'($random(seed));
			ev[j] = i;
			event_channel <= ev;
			src = 3'($random(seed));
			src[0] = !i;
			pwm_in <= src;
			src[0] = i;
			repeat (80) @(posedge mclk);
			outs;
		end
		wr(`DTU_OFS_CTRL, 32'h1);
		event_channel <= 16'h0;
		src = 3'h5;
		pwm_in <= src;
		// Let the longest dead time run out before any compare
		repeat (80) @(posedge mclk);
		e0 = $random(seed) & 14;
		for (fact = 0; fact < 4; fact++) begin
			wr(`DTU_OFS_FC, e0 | ((e0 + 1) << 8) | (fact << 16) | (15 << 24));
			for (i = 0; i < 4; i++) begin
				fsrc(i, 1'b1);
				repeat (5) @(posedge mclk);
				flt = 1;
				outs;
				fsrc(i, 1'b0);
				rd(`DTU_OFS_FSTAT, 1 << i);
				wr(`DTU_OFS_FCLR, 32'hF);
				repeat (5) @(posedge mclk);
				flt = 0;
				outs;
			end
		end
		fsrc(0, 1'b1);
		fsrc(3, 1'b1);
		repeat (5) @(posedge mclk);
		fsrc(0, 1'b0);
		fsrc(3, 1'b0);
		wr(`DTU_OFS_FCLR, 32'h1);
		repeat (5) @(posedge mclk);
		flt = 1;
		outs;
		rd(`DTU_OFS_FSTAT, 32'h8);
		wr(`DTU_OFS_FCLR, 32'h8);
		wr(`DTU_OFS_CTRL, 32'h101);
		dbg_halt <= 1'b1;
		repeat (5) @(posedge mclk);
		dbg_halt <= 1'b0;
		repeat (5) @(posedge mclk);
		rd(`DTU_OFS_FSTAT, 32'h0);
		flt = 0;
		outs;
		wr(`DTU_OFS_LOCK, 32'h1234);
		rd(`DTU_OFS_LOCK, 32'h1);
		wr(`DTU_OFS_CTRL, 32'h0);
		wr(`DTU_OFS_ROUTE, 32'h0);
		rd(`DTU_OFS_CTRL, 32'h101);
		rd(`DTU_OFS_ROUTE, 32'h3F);
		wr(`DTU_OFS_OGEN, 32'h15);
		rd(`DTU_OFS_OGEN, 32'h15);
		wr(`DTU_OFS_LOCK, 32'hCE80);
		rd(`DTU_OFS_LOCK, 32'h0);
		wr(`DTU_OFS_CTRL, 32'h0);
		rd(`DTU_OFS_CTRL, 32'h0);
		results;
	end
endmodule // tb
